//--- rtl/scr_result.sv
`timescale 1ns/1ps
module scr_result
  import scr_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  input  wire logic       cmd_wr_in,
  input  wire logic [7:0] cmd_data_in,
  input  wire logic       other_wr_in,
  input  wire logic       cmd_done_in,
  input  wire logic       invalid_in,
  input  wire logic [5:0] overflow_in,
  input  wire logic [1:0] th_sel_in,
  input  wire logic       th_wr_in,
  input  wire logic [7:0] th_data_in,
  input  wire logic [2:0] meas_valid_in,
  input  wire logic [7:0] meas_data_in,
  output logic            wake_out,
  output logic      [7:0] command_result_out,
  output logic            error_out,
  output logic      [2:0] prox_above_out
);
  logic [7:0] command_result;
  logic [7:0] next_result;
  logic [2:0] above;

  // wake only on a command write
  assign wake_out = cmd_wr_in; // RULE10

  always_comb begin
    next_result = command_result;
    if (cmd_done_in) begin
      if (command_result[7:4] == 4'h0) begin
        next_result = {4'h0, command_result[3:0] + 4'h1}; // RULE1
      end
    end
    // newest error wins, in fixed priority when several arrive together
    if (invalid_in) begin
      next_result = invalid_setting_code; // RULE3 RULE11
    end else if (overflow_in[ovf_prox_one]) begin
      next_result = prox_one_overflow_code; // RULE4
    end else if (overflow_in[ovf_prox_two]) begin
      next_result = prox_two_overflow_code; // RULE4
    end else if (overflow_in[ovf_prox_three]) begin
      next_result = prox_three_overflow_code; // RULE4
    end else if (overflow_in[ovf_visible]) begin
      next_result = visible_overflow_code; // RULE5
    end else if (overflow_in[ovf_infrared]) begin
      next_result = infrared_overflow_code; // RULE5
    end else if (overflow_in[ovf_aux]) begin
      next_result = aux_overflow_code; // RULE6
    end
    if (cmd_wr_in && cmd_data_in == no_operation_command) begin
      next_result = result_reset; // RULE2 RULE9
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      command_result <= result_reset;
    end else begin
      command_result <= next_result;
    end
  end

  assign command_result_out = command_result;
  assign error_out          = command_result[7:4] != 4'h0; // RULE8

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_prox
      logic [7:0] threshold;
      logic       above_q;
      always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
          threshold <= threshold_reset;
          above_q   <= 1'h0;
        end else begin
          if (th_wr_in && th_sel_in == 2'(g)) begin
            threshold <= th_data_in; // RULE7
          end
          if (meas_valid_in[g]) begin
            above_q <= meas_data_in > threshold; // RULE7
          end
        end
      end
      assign above[g] = above_q;
    end
  endgenerate
  assign prox_above_out = above;

  a_nop_clears: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE9
    cmd_wr_in && cmd_data_in == no_operation_command |=> command_result == 8'h00)
    else $error("nop did not clear result");
  a_invalid_code: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE3
    invalid_in && !cmd_wr_in |=> command_result == 8'h80)
    else $error("invalid setting code wrong");
  a_prox_one_ovf: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE4
    overflow_in == 6'h01 && !invalid_in && !cmd_wr_in |=> command_result == 8'h88)
    else $error("prox one overflow code wrong");
  a_prox_three_ovf: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE4
    overflow_in == 6'h04 && !invalid_in && !cmd_wr_in |=> command_result == 8'h8a)
    else $error("prox three overflow code wrong");
  a_infrared_ovf: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE5
    overflow_in == 6'h10 && !invalid_in && !cmd_wr_in |=> command_result == 8'h8d)
    else $error("infrared overflow code wrong");
  a_aux_ovf: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE6
    overflow_in == 6'h20 && !invalid_in && !cmd_wr_in |=> command_result == 8'h8e)
    else $error("aux overflow code wrong");
  a_count_step: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE1
    cmd_done_in && !invalid_in && overflow_in == 6'h00 && !cmd_wr_in
      && command_result[7:4] == 4'h0
    |=> command_result[7:4] == 4'h0
      && command_result[3:0] == $past(command_result[3:0]) + 4'h1)
    else $error("count did not advance");
  a_error_sticks: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE11
    error_out && !cmd_wr_in && !invalid_in && overflow_in == 6'h00 |=> $stable(command_result))
    else $error("error code changed");
  a_wake_cmd: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE10
    other_wr_in && !cmd_wr_in |-> !wake_out)
    else $error("wake on non-command write");

  sequence s_other_write;
    other_wr_in && !cmd_wr_in && !cmd_done_in && !invalid_in && overflow_in == 6'h00;
  endsequence

  sequence s_plain_command;
    cmd_wr_in && cmd_data_in != no_operation_command && !cmd_done_in && !invalid_in
      && overflow_in == 6'h00;
  endsequence

  sequence s_quiet_done;
    cmd_done_in && !cmd_wr_in && !invalid_in && overflow_in == 6'h00
      && command_result[7:4] == 4'h0;
  endsequence

  // two completions back to back
  sequence s_two_done;
    s_quiet_done ##1 s_quiet_done;
  endsequence

  // count cleared by a no-operation write, then one completion
  sequence s_nop_then_done;
    cmd_wr_in && cmd_data_in == no_operation_command ##1 s_quiet_done;
  endsequence

  // error code raised, then a completion that must be refused
  sequence s_invalid_then_done;
    invalid_in && !cmd_wr_in
    ##1 cmd_done_in && !cmd_wr_in && !invalid_in && overflow_in == 6'h00;
  endsequence

  // threshold written, then a measurement on the same channel
  sequence s_th_meas_one;
    th_wr_in && th_sel_in == 2'h0 ##1 meas_valid_in[0];
  endsequence

  sequence s_th_meas_two;
    th_wr_in && th_sel_in == 2'h1 ##1 meas_valid_in[1];
  endsequence

  sequence s_th_meas_three;
    th_wr_in && th_sel_in == 2'h2 ##1 meas_valid_in[2];
  endsequence

  a_prox_two_ovf: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE4
    overflow_in == 6'h02 && !invalid_in && !cmd_wr_in |=> command_result == 8'h89)
    else $error("prox two overflow code wrong");

  a_visible_ovf: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE5
    overflow_in == 6'h08 && !invalid_in && !cmd_wr_in |=> command_result == 8'h8c)
    else $error("visible overflow code wrong");

  a_other_inert: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE10
    s_other_write |=> $stable(command_result))
    else $error("other register write changed result");

  a_cmd_inert: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE11
    s_plain_command |=> $stable(command_result))
    else $error("plain command changed result");

  a_count_wrap: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE1
    command_result == 8'h0f && cmd_done_in && !cmd_wr_in && !invalid_in && overflow_in == 6'h00
    |=> command_result == 8'h00)
    else $error("count did not wrap");

  a_two_steps: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE1
    s_two_done |=> command_result[3:0] == $past(command_result[3:0], 2) + 4'h2)
    else $error("count skipped a completion");

  a_nop_count: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE2
    s_nop_then_done |=> command_result == 8'h01)
    else $error("count not restarted by nop");

  a_done_refused: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE3
    s_invalid_then_done |=> command_result == invalid_setting_code)
    else $error("completion overwrote error code");

  a_invalid_replaces: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE11
    error_out && invalid_in && !cmd_wr_in |=> command_result == invalid_setting_code)
    else $error("newest error did not replace old code");

  a_thresh_one: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE7
    s_th_meas_one |=> prox_above_out[0] == ($past(meas_data_in) > $past(th_data_in, 2)))
    else $error("proximity one threshold compare wrong");

  a_thresh_two: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE7
    s_th_meas_two |=> prox_above_out[1] == ($past(meas_data_in) > $past(th_data_in, 2)))
    else $error("proximity two threshold compare wrong");

  a_thresh_three: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE7
    s_th_meas_three |=> prox_above_out[2] == ($past(meas_data_in) > $past(th_data_in, 2)))
    else $error("proximity three threshold compare wrong");

  a_above_hold: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE7
    meas_valid_in == 3'h0 |=> $stable(prox_above_out))
    else $error("threshold flags moved without a measurement");

  a_result_legal: assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE8 RULE11
    command_result[7:4] == 4'h0 || command_result == invalid_setting_code
    || command_result == prox_one_overflow_code || command_result == prox_two_overflow_code
    || command_result == prox_three_overflow_code || command_result == visible_overflow_code
    || command_result == infrared_overflow_code || command_result == aux_overflow_code)
    else $error("result holds an undefined code");

  a_reset_clear: assert property (@(posedge clock_in) // RULE11
    !rst_b_in |=> command_result == result_reset && prox_above_out == 3'h0)
    else $error("reset did not clear result");
endmodule

//--- rtl/scr_pkg.sv
// How it works
// RULE1 - success keeps nibble zero, count increments
// RULE2 - no-operation command clears the count
// RULE3 - invalid setting loads 1000 0000
// RULE4 - proximity overflows report 88, 89, 8a
// RULE5 - visible 8c, infrared 8d overflow codes
// RULE6 - auxiliary overflow reports 8e
// RULE7 - three 8-bit proximity thresholds compared
// RULE8 - nonzero upper nibble flags error
// RULE9 - no-operation command zeroes result
// RULE10 - only command writes wake sequencer
// RULE11 - result holds one newest code
package scr_pkg;
  localparam logic [7:0] no_operation_command     = 8'h00;
  localparam logic [7:0] result_reset             = 8'h00;
  localparam logic [7:0] invalid_setting_code     = 8'h80;
  localparam logic [7:0] prox_one_overflow_code   = 8'h88;
  localparam logic [7:0] prox_two_overflow_code   = 8'h89;
  localparam logic [7:0] prox_three_overflow_code = 8'h8a;
  localparam logic [7:0] visible_overflow_code    = 8'h8c;
  localparam logic [7:0] infrared_overflow_code   = 8'h8d;
  localparam logic [7:0] aux_overflow_code        = 8'h8e;
  localparam logic [7:0] threshold_reset          = 8'h00;
  localparam int         ovf_prox_one             = 0;
  localparam int         ovf_prox_two             = 1;
  localparam int         ovf_prox_three           = 2;
  localparam int         ovf_visible              = 3;
  localparam int         ovf_infrared             = 4;
  localparam int         ovf_aux                  = 5;
endpackage

//--- bench/scr_host.sv
`timescale 1ns/1ps
module scr_host (
  input  wire logic       clock_in,
  output logic            cmd_wr_out,
  output logic      [7:0] cmd_data_out
);
  initial begin
    cmd_wr_out = 1'b0;
    cmd_data_out = 8'h00;
  end
  // one-cycle command write, data flipped once released
  task automatic issue(input logic [7:0] c);
    @(posedge clock_in) #1;
    cmd_wr_out = 1'b1;
    cmd_data_out = c;
    @(posedge clock_in) #1;
    cmd_wr_out = 1'b0;
    cmd_data_out = ~c;
  endtask
endmodule

//--- bench/scr_result_bench.sv
`timescale 1ns/1ps
module scr_result_bench;
  import scr_pkg::*;
  localparam int timeout_cycles = 3000;
  logic       clk   = 1'h0;
  logic       rst_b = 1'h0;
  logic       done  = 1'h0;
  logic       inv   = 1'h0;
  logic       oth   = 1'h0;
  logic       thw   = 1'h0;
  logic       wake;
  logic       err;
  logic       cw;
  logic [5:0] ovf   = 6'h00;
  logic [1:0] tsel  = 2'h0;
  logic [2:0] mv    = 3'h0;
  logic [2:0] above;
  logic [7:0] td    = 8'h00;
  logic [7:0] md    = 8'h00;
  logic [7:0] res;
  logic [7:0] cd;
  logic [7:0] codes [6] = '{prox_one_overflow_code, prox_two_overflow_code,
    prox_three_overflow_code, visible_overflow_code, infrared_overflow_code, aux_overflow_code};
  int         fail_count  = 0;
  int         comparisons = 0;
  int         cyc         = 0;
  scr_host host (.clock_in(clk), .cmd_wr_out(cw), .cmd_data_out(cd));
  scr_result dut (.clock_in(clk), .rst_b_in(rst_b), .cmd_wr_in(cw), .cmd_data_in(cd),
    .other_wr_in(oth), .cmd_done_in(done), .invalid_in(inv), .overflow_in(ovf),
    .th_sel_in(tsel), .th_wr_in(thw), .th_data_in(td), .meas_valid_in(mv),
    .meas_data_in(md), .wake_out(wake), .command_result_out(res), .error_out(err),
    .prox_above_out(above));
  initial begin
    forever begin
      #10 clk = ~clk;
    end
  end
  task automatic end_of_test;
    $display("%0d mismatches, %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == timeout_cycles) begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic tick;
    @(posedge clk) #1;
  endtask
  task automatic t_count;
    tick;
    done = 1'h1;
    repeat (17) tick;
    done = 1'h0;
    chk(res, 8'h01);
    chk({7'h00, err}, 8'h00);
    oth = 1'h1;
    chk({7'h00, wake}, 8'h00);
    tick;
    oth = 1'h0;
    chk(res, 8'h01);
    fork
      host.issue(8'h05);
      begin
        @(posedge cw);
        #1;
        chk({7'h00, wake}, 8'h01);
      end
    join
    chk(res, 8'h01);
    host.issue(no_operation_command);
    chk(res, result_reset);
    $display("count test done");
  endtask
  task automatic t_error;
    inv = 1'h1;
    ovf = 6'h3f;
    tick;
    inv = 1'h0;
    ovf = 6'h00;
    chk(res, invalid_setting_code);
    chk({7'h00, err}, 8'h01);
    done = 1'h1;
    tick;
    done = 1'h0;
    chk(res, invalid_setting_code);
    ovf = 6'h20;
    tick;
    ovf = 6'h00;
    chk(res, aux_overflow_code);
    inv = 1'h1;
    tick;
    inv = 1'h0;
    chk(res, invalid_setting_code);
    for (int i = 0; i < 6; i++) begin
      host.issue(no_operation_command);
      chk(res, result_reset);
      ovf = 6'h3f << i;
      tick;
      chk(res, codes[i]);
      ovf = 6'h01 << i;
      tick;
      ovf = 6'h00;
      chk(res, codes[i]);
    end
    host.issue(no_operation_command);
    $display("error test done");
  endtask
  task automatic t_thresh;
    for (int c = 0; c < 3; c++) begin
      tsel = c[1:0];
      td = 8'h50 + c[7:0];
      thw = 1'h1;
      tick;
      thw = 1'h0;
      md = 8'h51;
      mv = 3'h1 << c;
      tick;
      mv = 3'h0;
      chk({7'h00, above[c]}, {7'h00, c == 0});
    end
    $display("threshold test done");
  endtask
  task automatic t_reset;
    host.issue(no_operation_command);
    done = 1'h1;
    tick;
    done = 1'h0;
    chk(res, 8'h01);
    rst_b = 1'h0;
    repeat (2) tick;
    rst_b = 1'h1;
    chk(res, result_reset);
    chk({5'h00, above}, 8'h00);
    md = 8'h01;
    mv = 3'h1;
    tick;
    mv = 3'h0;
    chk({7'h00, above[0]}, 8'h01);
    $display("reset test done");
  endtask
  initial begin
    repeat (20) tick;
    rst_b = 1'h1;
    chk(res, result_reset);
    t_count;
    t_error;
    t_thresh;
    t_reset;
    end_of_test;
  end
endmodule
